// >>> hdl/icc_params.svh
// Constants of the instruction cache controller
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
`define ICC_CACHE_BYTES 8192
`define ICC_WAYS 4
`define ICC_LINE_BYTES 32
`define ICC_SETS 64
`define ICC_LINE_BEATS 3'h4
`define ICC_LAST_BEAT 2'h3
`define ICC_LAST_SET 6'h3F
`define ICC_SET_LSB 5
`define ICC_SET_MSB 10
`define ICC_TAG_LSB 11
`define ICC_LRU_RST 8'hE4
`define ICC_NVM_BASE 32'h6000_0000
`define ICC_NVM_MASK 32'hFFF8_0000
`define ICC_DDR_BASE 32'hA000_0000
`define ICC_DDR_MASK 32'hE000_0000
`endif

// >>> hdl/icc_pkg.sv
// Types of the instruction cache controller
package icc_pkg;
    typedef enum logic [1:0] {ICC_IDLE, ICC_FILL, ICC_BYP} icc_st_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } icc_req_t;
    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } icc_rsp_t;
    typedef struct packed {
        logic req;
        logic ddr_sel;
        logic [31:0] addr;
        logic [2:0] beats;
    } icc_mreq_t;
    typedef struct packed {
        icc_st_t st;
        logic [1:0] pend;
        logic [1:0][31:0] paddr;
        icc_rsp_t [1:0] rsp;
        icc_mreq_t mreq;
        logic [1:0] beat;
        logic port;
        logic pre;
        logic [5:0] set_cnt;
        logic [1:0] victim;
        logic locked;
        logic lock_prev;
    } icc_state_t;
endpackage

// >>> hdl/icc_top.sv
// Four-way instruction cache shared by two code fetch ports
// Contract
// R1: The cache holds 8 Kbyte in sets of four ways with set-associative lookup.
// R2: A fetch that hits is answered with no wait state.
// R3: The instruction and data code ports share one cache array.
// R4: A miss fills a whole line and replaces the least recently used way.
// R5: Fetches from external DDR or on-chip nonvolatile memory are cached.
// R6: Locked mode preloads a fixed code segment that misses never evict.
// R7: The cache can be disabled so that fetch timing does not depend on it.
// R8: Accesses to the 64-bit nonvolatile memory are cacheable.
// R9: Disabled means straight forwarding with no allocation; reset invalidates.
`timescale 1ns/100ps
`include "icc_params.svh"
module icc_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Configuration
    input wire logic CACHE_EN,
    input wire logic LOCK_EN,
    input wire logic [31:0] LOCK_BASE,
    output logic LOCKED,
    // Code fetch ports
    input icc_pkg::icc_req_t ICODE_REQ,
    input icc_pkg::icc_req_t DCODE_REQ,
    output icc_pkg::icc_rsp_t ICODE_RSP,
    output icc_pkg::icc_rsp_t DCODE_RSP,
    // Backing memory
    output icc_pkg::icc_mreq_t MEM_REQ,
    input wire logic MEM_ACK,
    input wire logic [63:0] MEM_RDATA
);
    import icc_pkg::*;

    localparam int NLINE = `ICC_CACHE_BYTES / `ICC_LINE_BYTES; // R1
    localparam int NBEAT = NLINE * 4;

    icc_state_t s_ff, nxt_s;
    // Arrays live in plain flops; no reset on data to save area
    logic [63:0] data_mem [NBEAT];
    logic [20:0] tag_mem [`ICC_SETS][`ICC_WAYS];
    logic [`ICC_WAYS-1:0] vld_mem [`ICC_SETS];
    logic [7:0] lru_mem [`ICC_SETS];

    icc_req_t req [2];
    logic [31:0] lk_addr [2];
    logic [5:0] lk_set [2];
    logic hit [2];
    logic [1:0] hway [2];
    logic [31:0] hdata [2];
    logic cach [2];
    logic [1:0] vic [2];
    logic ans_hit [2];
    logic fill_start, fill_done;
    logic [7:0] lru_a, lru_b;

    assign req[0] = ICODE_REQ;
    assign req[1] = DCODE_REQ;

    function automatic logic in_region(input logic [31:0] a);
        in_region = ((a & `ICC_NVM_MASK) == `ICC_NVM_BASE) ||
                    ((a & `ICC_DDR_MASK) == `ICC_DDR_BASE);
    endfunction

    // Age every way younger than the touched one, touched becomes zero
    function automatic logic [7:0] touch(input logic [7:0] a,
                                         input logic [1:0] w);
        logic [7:0] r;
        r = a;
        for (int i = 0; i < 4; i++) begin
            if (a[i*2+:2] < a[w*2+:2]) begin
                r[i*2+:2] = a[i*2+:2] + 2'h1;
            end
        end
        r[w*2+:2] = 2'h0;
        touch = r;
    endfunction

    // One lookup per port per cycle in the shared array
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [63:0] beat_w;
        assign lk_addr[p] = s_ff.pend[p] ? s_ff.paddr[p] : req[p].addr;
        assign lk_set[p] = lk_addr[p][`ICC_SET_MSB:`ICC_SET_LSB];
        assign cach[p] = CACHE_EN && in_region(lk_addr[p]); // R5 R8 R7
        always_comb begin
            hit[p] = 1'b0;
            hway[p] = 2'h0;
            for (int w = 0; w < `ICC_WAYS; w++) begin
                if (vld_mem[lk_set[p]][w] && tag_mem[lk_set[p]][w] ==
                    lk_addr[p][31:`ICC_TAG_LSB]) begin // R1 R3
                    hit[p] = 1'b1;
                    hway[p] = 2'(w);
                end
            end
        end
        assign beat_w = data_mem[{lk_set[p], hway[p], lk_addr[p][4:3]}];
        assign hdata[p] = lk_addr[p][2] ? beat_w[63:32] : beat_w[31:0];
        // Oldest way wins; way 0 is off limits while locked
        always_comb begin
            vic[p] = (s_ff.locked && LOCK_EN) ? 2'h1 : 2'h0; // R6
            for (int w = 1; w < `ICC_WAYS; w++) begin
                if (lru_mem[lk_set[p]][w*2+:2] >
                    lru_mem[lk_set[p]][vic[p]*2+:2]) begin // R4
                    vic[p] = 2'(w);
                end
            end
        end
    end

    // Control: port answers, line fills, bypass reads, lock preload
    always_comb begin
        logic sel;
        sel = !s_ff.pend[0];
        nxt_s = s_ff;
        nxt_s.mreq.req = 1'b0;
        fill_start = 1'b0;
        fill_done = 1'b0;
        for (int p = 0; p < 2; p++) begin
            nxt_s.rsp[p].rvalid = 1'b0;
            ans_hit[p] = 1'b0;
            if (s_ff.pend[p] || req[p].valid) begin
                if (cach[p] && hit[p]) begin
                    ans_hit[p] = 1'b1; // R2
                    nxt_s.rsp[p].rvalid = 1'b1;
                    nxt_s.rsp[p].rdata = hdata[p];
                    nxt_s.pend[p] = 1'b0;
                end else if (!s_ff.pend[p]) begin
                    nxt_s.pend[p] = 1'b1;
                    nxt_s.paddr[p] = req[p].addr;
                end
            end
        end
        if (!LOCK_EN) begin
            nxt_s.locked = 1'b0;
        end
        unique case (s_ff.st)
            ICC_IDLE: begin
                nxt_s.lock_prev = LOCK_EN;
                if (LOCK_EN && !s_ff.lock_prev) begin
                    // Segment is one way deep: one line into way 0 per set
                    nxt_s.pre = 1'b1; // R6
                    nxt_s.set_cnt = 6'h0;
                    nxt_s.victim = 2'h0;
                    nxt_s.mreq.req = 1'b1;
                    nxt_s.mreq.ddr_sel = (LOCK_BASE & `ICC_DDR_MASK) ==
                        `ICC_DDR_BASE;
                    nxt_s.mreq.addr = {LOCK_BASE[31:11], 11'h0};
                    nxt_s.mreq.beats = `ICC_LINE_BEATS;
                    nxt_s.beat = 2'h0;
                    fill_start = 1'b1;
                    nxt_s.st = ICC_FILL;
                end else if (s_ff.pend[sel] && !(cach[sel] && hit[sel]))
                begin
                    nxt_s.port = sel;
                    nxt_s.beat = 2'h0;
                    nxt_s.mreq.req = 1'b1;
                    nxt_s.mreq.ddr_sel = (s_ff.paddr[sel] &
                        `ICC_DDR_MASK) == `ICC_DDR_BASE;
                    if (cach[sel]) begin
                        // Whole line, victim by age
                        nxt_s.mreq.addr = {s_ff.paddr[sel][31:5], 5'h0};
                        nxt_s.mreq.beats = `ICC_LINE_BEATS; // R4
                        nxt_s.victim = vic[sel];
                        fill_start = 1'b1;
                        nxt_s.st = ICC_FILL;
                    end else begin
                        // Straight through, nothing allocated
                        nxt_s.mreq.addr = {s_ff.paddr[sel][31:3], 3'h0};
                        nxt_s.mreq.beats = 3'h1; // R9 R7
                        nxt_s.st = ICC_BYP;
                    end
                end
            end
            ICC_FILL: begin
                if (MEM_ACK) begin
                    nxt_s.beat = s_ff.beat + 2'h1;
                    if (!s_ff.pre && s_ff.beat ==
                        s_ff.paddr[s_ff.port][4:3]) begin
                        nxt_s.rsp[s_ff.port].rdata =
                            s_ff.paddr[s_ff.port][2] ? MEM_RDATA[63:32] :
                            MEM_RDATA[31:0];
                    end
                    if (s_ff.beat == `ICC_LAST_BEAT) begin
                        fill_done = 1'b1;
                        nxt_s.st = ICC_IDLE;
                        if (s_ff.pre && s_ff.set_cnt != `ICC_LAST_SET) begin
                            nxt_s.set_cnt = s_ff.set_cnt + 6'h1;
                            nxt_s.mreq.req = 1'b1;
                            nxt_s.mreq.addr = s_ff.mreq.addr + 32'h20;
                            nxt_s.beat = 2'h0;
                            fill_start = 1'b1;
                            nxt_s.st = ICC_FILL;
                        end else if (s_ff.pre) begin
                            nxt_s.pre = 1'b0;
                            nxt_s.locked = LOCK_EN; // R6
                        end else begin
                            nxt_s.rsp[s_ff.port].rvalid = 1'b1;
                            nxt_s.pend[s_ff.port] = 1'b0;
                        end
                    end
                end
            end
            ICC_BYP: begin
                if (MEM_ACK) begin
                    nxt_s.rsp[s_ff.port].rvalid = 1'b1; // R9
                    nxt_s.rsp[s_ff.port].rdata =
                        s_ff.paddr[s_ff.port][2] ? MEM_RDATA[63:32] :
                        MEM_RDATA[31:0];
                    nxt_s.pend[s_ff.port] = 1'b0;
                    nxt_s.st = ICC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Age updates; a second hit in the same set builds on the first
    assign lru_a = touch(lru_mem[lk_set[0]], hway[0]);
    assign lru_b = (ans_hit[0] && lk_set[1] == lk_set[0]) ?
        touch(lru_a, hway[1]) : touch(lru_mem[lk_set[1]], hway[1]);

    // Array writes; victim is invalidated up front so no half line hits
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int s = 0; s < `ICC_SETS; s++) begin
                vld_mem[s] <= '0; // R9
                lru_mem[s] <= `ICC_LRU_RST;
            end
        end else begin
            if (ans_hit[0]) begin
                lru_mem[lk_set[0]] <= lru_a;
            end
            if (ans_hit[1]) begin
                lru_mem[lk_set[1]] <= lru_b;
            end
            if (s_ff.st == ICC_FILL && MEM_ACK) begin
                data_mem[{s_ff.mreq.addr[10:5], s_ff.victim, s_ff.beat}]
                    <= MEM_RDATA; // R4
            end
            if (fill_done) begin
                vld_mem[s_ff.mreq.addr[10:5]][s_ff.victim] <= 1'b1;
                tag_mem[s_ff.mreq.addr[10:5]][s_ff.victim] <=
                    s_ff.mreq.addr[31:11];
                lru_mem[s_ff.mreq.addr[10:5]] <=
                    touch(lru_mem[s_ff.mreq.addr[10:5]], s_ff.victim);
            end
            if (fill_start) begin
                vld_mem[nxt_s.mreq.addr[10:5]][nxt_s.victim] <= 1'b0;
            end
        end
    end

    // Outputs straight from the state flops
    assign ICODE_RSP = s_ff.rsp[0];
    assign DCODE_RSP = s_ff.rsp[1];
    assign MEM_REQ = s_ff.mreq;
    assign LOCKED = s_ff.locked;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_ihit;
        req[0].valid && !s_ff.pend[0] && cach[0] && hit[0];
    endsequence
    sequence s_dhit;
        req[1].valid && !s_ff.pend[1] && cach[1] && hit[1];
    endsequence
    a_ihit_no_wait: assert property (s_ihit |=> ICODE_RSP.rvalid) // R2
        else $error("I-code hit not answered next cycle");
    a_ihit_data: assert property (s_ihit ##1 1'b1 |-> // R2
        ICODE_RSP.rdata == $past(hdata[0]))
        else $error("I-code hit returned wrong word");
    a_dport_shared: assert property (s_dhit |=> DCODE_RSP.rvalid) // R3
        else $error("D-code hit not answered next cycle");
    a_miss_fill_len: assert property (s_ff.st == ICC_IDLE && fill_start // R4
        |=> MEM_REQ.req && MEM_REQ.beats == `ICC_LINE_BEATS)
        else $error("Line fill not a full line");
    a_lock_keeps_way: assert property (s_ff.locked && LOCK_EN && // R6
        fill_start && !s_ff.pre |-> nxt_s.victim != 2'h0)
        else $error("Locked way chosen as victim");
    a_off_no_alloc: assert property (!CACHE_EN && fill_start |-> // R9
        nxt_s.pre)
        else $error("Line allocated while disabled");
    a_off_bypass: assert property (s_ff.st == ICC_BYP |-> // R7
        MEM_REQ.beats == 3'h1 && $past(s_ff.st) != ICC_FILL)
        else $error("Bypass read not single beat");
    a_nvm_cached: assert property (CACHE_EN && s_ff.st == ICC_IDLE && // R8 R5
        nxt_s.st == ICC_BYP |-> !in_region(s_ff.paddr[s_ff.pend[0] ?
        0 : 1]))
        else $error("Cacheable fetch bypassed the cache");
    a_reset_invalid: assert property ($fell(RST) |-> // R9
        vld_mem[lk_set[0]] == '0 && vld_mem[lk_set[1]] == '0)
        else $error("Lines valid after reset");
endmodule

// >>> dv/icc_mem_model.sv
// Backing memory model answering line fills and single-beat reads
`timescale 1ns/100ps
module icc_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request side
    input icc_pkg::icc_mreq_t mreq,
    input wire logic slow,
    // Answer side
    output logic ack,
    output logic [63:0] rdata,
    output logic [15:0] req_cnt
);
    import icc_pkg::*;
    logic [2:0] left_ff;
    logic [31:0] cur_ff;
    logic [1:0] dly_ff;
    // Beats go out in address order; idle data toggles so stale reads show
    always_ff @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (rst) begin
            left_ff <= 3'h0;
            req_cnt <= 16'h0;
            rdata <= 64'h0;
        end else if (mreq.req) begin
            req_cnt <= req_cnt + 16'h1;
            left_ff <= mreq.beats;
            cur_ff <= {mreq.addr[31:3], 3'h0};
            dly_ff <= slow ? 2'h3 : 2'h0;
        end else if (left_ff != 3'h0) begin
            if (dly_ff != 2'h0) begin
                dly_ff <= dly_ff - 2'h1;
            end else begin
                ack <= 1'b1;
                rdata <= {~{cur_ff[31:3], 3'h4}, ~{cur_ff[31:3], 3'h0}};
                cur_ff <= cur_ff + 32'h8;
                left_ff <= left_ff - 3'h1;
                dly_ff <= slow ? 2'h3 : 2'h0;
            end
        end
    end
endmodule

// >>> dv/icc_top_bench.sv
// Self-checking bench for the instruction cache controller
`timescale 1ns/100ps
module icc_top_bench;
    import icc_pkg::*;
    localparam logic [31:0] NVM = 32'h6000_0000;
    localparam logic [31:0] DDR = 32'hA000_0000;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic cache_en = 1'b1;
    logic lock_en = 1'b0;
    logic slow = 1'b0;
    logic [31:0] lock_base = 32'h0;
    icc_req_t ireq = '0;
    icc_req_t dreq = '0;
    icc_rsp_t irsp;
    icc_rsp_t drsp;
    icc_mreq_t mreq;
    logic locked;
    logic mem_ack;
    logic [63:0] mem_rdata;
    logic [15:0] req_cnt;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;

    icc_top icc_top_inst (
        .CLK(CLK), .RST(RST), .CACHE_EN(cache_en), .LOCK_EN(lock_en),
        .LOCK_BASE(lock_base), .LOCKED(locked), .ICODE_REQ(ireq),
        .DCODE_REQ(dreq), .ICODE_RSP(irsp), .DCODE_RSP(drsp),
        .MEM_REQ(mreq), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata)
    );
    icc_mem_model icc_mem_model_inst (
        .clk(CLK), .rst(RST), .mreq(mreq), .slow(slow),
        .ack(mem_ack), .rdata(mem_rdata), .req_cnt(req_cnt)
    );

    // 25 MHz clock
    always #20 CLK = ~CLK;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge CLK);
        RST <= 1'b1;
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
    endtask

    // One fetch; beats 0 means a hit is expected, else the burst length
    task automatic fetch(input logic dp, input logic [31:0] a,
                         input logic [2:0] beats, input logic ddr);
        int n;
        logic [15:0] c0;
        logic v;
        logic [31:0] d;
        logic [31:0] ea;
        n = 0;
        v = 1'b0;
        c0 = req_cnt;
        ea = (beats == 3'h4) ? {a[31:5], 5'h0} : {a[31:3], 3'h0};
        @(posedge CLK);
        if (dp) dreq <= '{1'b1, a};
        else ireq <= '{1'b1, a};
        // One-cycle valid; the port latches the address when it takes it
        while (v !== 1'b1 && n < 400) begin
            @(posedge CLK);
            ireq.valid <= 1'b0;
            dreq.valid <= 1'b0;
            #1;
            n++;
            v = dp ? drsp.rvalid : irsp.rvalid;
            d = dp ? drsp.rdata : irsp.rdata;
        end
        chk(v === 1'b1 && d === ~{a[31:2], 2'h0}, "fetch data");
        if (beats == 3'h0) begin
            chk(n == 1 && req_cnt === c0, "hit not immediate");
        end else begin
            chk(n > 1 && req_cnt === c0 + 16'h1, "miss count");
            chk(mreq.beats === beats && mreq.addr === ea, "burst");
            if (beats == 3'h4) chk(mreq.ddr_sel === ddr, "source");
        end
        // Return on an edge so the caller drives on it
        @(posedge CLK);
    endtask

    task automatic t_basic();
        do_reset();
        fetch(1'b0, NVM + 32'h104, 3'h4, 1'b0);
        fetch(1'b0, NVM + 32'h100, 3'h0, 1'b0);
        fetch(1'b1, NVM + 32'h118, 3'h0, 1'b0);
        fetch(1'b1, DDR + 32'h2000, 3'h4, 1'b1);
        fetch(1'b0, DDR + 32'h2004, 3'h0, 1'b1);
        fetch(1'b0, 32'h2000_0010, 3'h1, 1'b0);
        fetch(1'b0, 32'h2000_0010, 3'h1, 1'b0);
        slow <= 1'b1;
        fetch(1'b1, NVM + 32'h3E0, 3'h4, 1'b0);
        fetch(1'b0, NVM + 32'h3FC, 3'h0, 1'b0);
        slow <= 1'b0;
    endtask

    // Five tags in one set: the least recently used one goes
    task automatic t_lru();
        do_reset();
        for (int k = 0; k < 4; k++) begin
            fetch(1'b0, NVM + 32'h40 + 32'h800 * k, 3'h4, 1'b0);
        end
        fetch(1'b0, NVM + 32'h40, 3'h0, 1'b0);
        fetch(1'b0, NVM + 32'h2040, 3'h4, 1'b0);
        fetch(1'b0, NVM + 32'h40, 3'h0, 1'b0);
        fetch(1'b0, NVM + 32'h1040, 3'h0, 1'b0);
        fetch(1'b0, NVM + 32'h1840, 3'h0, 1'b0);
        fetch(1'b0, NVM + 32'h840, 3'h4, 1'b0);
        do_reset();
        fetch(1'b0, NVM + 32'h40, 3'h4, 1'b0);
    endtask

    task automatic t_off();
        do_reset();
        cache_en <= 1'b0;
        fetch(1'b0, NVM + 32'h204, 3'h1, 1'b0);
        fetch(1'b1, NVM + 32'h204, 3'h1, 1'b0);
        cache_en <= 1'b1;
        fetch(1'b0, NVM + 32'h204, 3'h4, 1'b0);
        fetch(1'b1, NVM + 32'h200, 3'h0, 1'b0);
    endtask

    // Both ports miss together: the I-code line is fetched first
    task automatic t_both();
        int n;
        logic iv;
        logic dv;
        n = 0;
        iv = 1'b0;
        dv = 1'b0;
        do_reset();
        @(posedge CLK);
        ireq <= '{1'b1, NVM + 32'h404};
        dreq <= '{1'b1, DDR + 32'h608};
        @(posedge CLK);
        ireq.valid <= 1'b0;
        dreq.valid <= 1'b0;
        while (!(iv && dv) && n < 400) begin
            @(posedge CLK);
            #1;
            n++;
            if (irsp.rvalid === 1'b1) begin
                iv = 1'b1;
                chk(!dv && irsp.rdata === ~(NVM + 32'h404), "I-code");
            end
            if (drsp.rvalid === 1'b1) begin
                dv = 1'b1;
                chk(iv && drsp.rdata === ~(DDR + 32'h608), "D-code");
            end
        end
        chk(iv && dv && req_cnt === 16'h2, "both served");
        @(posedge CLK);
    endtask

    task automatic t_lock();
        int n;
        n = 0;
        do_reset();
        lock_base <= NVM + 32'h800;
        lock_en <= 1'b1;
        while (locked !== 1'b1 && n < 3000) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk(locked === 1'b1 && req_cnt === 16'h40, "preload");
        fetch(1'b0, NVM + 32'h840, 3'h0, 1'b0);
        for (int k = 2; k < 6; k++) begin
            fetch(1'b1, NVM + 32'h40 + 32'h800 * k, 3'h4, 1'b0);
        end
        fetch(1'b0, NVM + 32'h844, 3'h0, 1'b0);
        lock_en <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        chk(locked === 1'b0, "unlock");
    endtask

    initial begin
        t_basic();
        t_lru();
        t_off();
        t_both();
        t_lock();
        close_out();
    end
endmodule
